// file: core/dea_pkg.sv
package dea_pkg;
    // Register byte offsets on the slave port
    localparam logic [4:0]  OFS_ERR_FLAGS = 5'h00;
    localparam logic [4:0]  OFS_ERR_CLEAR = 5'h04;
    localparam logic [4:0]  OFS_REASSERT  = 5'h08;
    localparam logic [4:0]  OFS_IRQ_STAT  = 5'h0c;
    localparam logic [4:0]  OFS_IRQ_CLEAR = 5'h10;
    localparam logic [4:0]  OFS_IRQ_EN    = 5'h14;

    // Field positions
    localparam int          BIT_CCODE_OVF = 16;
    localparam int          BIT_Q1_THRESH = 1;
    localparam int          BIT_Q0_THRESH = 0;
    localparam int          BIT_REASSERT  = 0;
    localparam int          BIT_RESERVED1 = 1;

    // Block interrupt status bits
    localparam int          IRQ_W         = 3;
    localparam int          IRQ_ERR_PULSE = 0;
    localparam int          IRQ_CCODE_SET = 1;
    localparam int          IRQ_QTHR_SET  = 2;

    // Documented defaults
    localparam int          CCODE_MAX_DEF = 31;
    localparam int          CCODE_W_DEF   = 6;
    localparam int          QCNT_W_DEF    = 5;
    localparam int          NQ_DEF        = 2;
    localparam int          DMA_MISS_W    = 32;
    localparam int          QDMA_MISS_W   = 8;
    localparam int          DATA_W        = 32;
    localparam logic [31:0] RD_ZERO       = 32'h0000_0000;
endpackage : dea_pkg

// file: core/dea_irq_if.sv
interface dea_irq_if;
    logic any_err;
    logic reassert;
    logic pulse;

    modport gen (
        input  any_err,
        input  reassert,
        output pulse
    );
    modport ctl (
        output any_err,
        output reassert,
        input  pulse
    );
endinterface : dea_irq_if

// file: core/dea_irq_gen.sv
module dea_irq_gen (
    input  wire logic clk,
    input  wire logic rstn,
    dea_irq_if.gen    irq_bus
);
    import dea_pkg::*;

    typedef struct packed {
        logic any_q;
        logic pulse;
    } dea_gen_state_s;

    dea_gen_state_s st;
    dea_gen_state_s next_st;

    always_comb begin
        next_st = st;
        next_st.any_q = irq_bus.any_err;
        // A rise from all clear, or a reassert while errors remain
        next_st.pulse = (irq_bus.any_err & ~st.any_q)
                      | (irq_bus.reassert & irq_bus.any_err);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign irq_bus.pulse = st.pulse;
endmodule : dea_irq_gen

// file: core/dea_error_aggregator.sv
// Overview of operation
// - Set overflow flag bit 16, hold until cleared
// - Queue 1 threshold sets bit 1, sticky
// - Queue 0 threshold sets bit 0, sticky
// - Clear register: ones clear, zeros ignored
// - Clear bit 16 clears overflow flag
// - Clear bit 1 also clears queue 1 status
// - Clear bit 0 also clears queue 0 status
// - Any error flag raises error interrupt
// - Re-raise only on all-clear to some-set
// - Reassert write of one pulses if errors remain
// - Overflow when outstanding codes exceed 31
// - Threshold error when count reaches threshold
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
module dea_error_aggregator #(
    parameter int NQ        = dea_pkg::NQ_DEF,
    parameter int QCNT_W    = dea_pkg::QCNT_W_DEF,
    parameter int CCODE_W   = dea_pkg::CCODE_W_DEF,
    parameter int CCODE_MAX = dea_pkg::CCODE_MAX_DEF
) (
    input  wire logic                               clk,
    input  wire logic                               rstn,
    input  wire logic [4:0]                         avs_address,
    input  wire logic                               avs_read,
    input  wire logic                               avs_write,
    input  wire logic [dea_pkg::DATA_W-1:0]         avs_writedata,
    input  wire logic [3:0]                         avs_byteenable,
    output logic      [dea_pkg::DATA_W-1:0]         avs_readdata,
    output logic                                    avs_waitrequest,
    input  wire logic [dea_pkg::DMA_MISS_W-1:0]     dma_event_missed_flags,
    input  wire logic [dea_pkg::QDMA_MISS_W-1:0]    qdma_event_missed_flags,
    input  wire logic [CCODE_W-1:0]                 ccode_outstanding,
    input  wire logic [NQ-1:0][QCNT_W-1:0]          queue_count,
    input  wire logic [NQ-1:0][QCNT_W-1:0]          queue_watermark_threshold,
    output logic      [NQ-1:0]                      queue_status_clear,
    output logic                                    error_irq,
    output logic                                    irq
);
    import dea_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    if (NQ < 1 || NQ > BIT_Q1_THRESH + 1) begin : g_bad_nq
        $error("NQ must be 1 or 2");
    end
    if (CCODE_MAX >= 2 ** CCODE_W - 1) begin : g_bad_cc
        $error("CCODE_W too narrow for CCODE_MAX");
    end

    localparam logic [CCODE_W-1:0] CC_LIMIT = CCODE_W'(CCODE_MAX);

    ////////////////////////////////////////////////////////////////////////////
    // Assertion clocking

    // One clock domain, so every property below shares this clock and reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic                ccode_ovf;
        logic [NQ-1:0]       qthresh;
        logic                ack;
        logic [DATA_W-1:0]   rdata;
        logic                rsv_bit;
        logic [IRQ_W-1:0]    istat;
        logic [IRQ_W-1:0]    ien;
        logic                irq;
        logic [NQ-1:0]       qclr;
    } dea_state_s;

    dea_state_s          st;
    dea_state_s          next_st;

    logic                req;
    logic                wr_go;
    logic [DATA_W-1:0]   wmask;
    logic [DATA_W-1:0]   wm;
    logic [DATA_W-1:0]   err_clr;
    logic [DATA_W-1:0]   err_word;
    logic                ccode_set;
    logic [NQ-1:0]       q_set;
    logic                any_err;
    logic                reassert;

    dea_irq_if           irq_bus ();

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    // One wait state: reads are sampled while waiting, writes land at release
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~st.ack;
    assign wr_go           = avs_write & st.ack;

    genvar gb;
    for (gb = 0; gb < DATA_W / 8; gb++) begin : g_lane
        assign wmask[gb*8 +: 8] = {8{avs_byteenable[gb]}};
    end

    assign wm       = avs_writedata & wmask;
    assign err_clr  = (wr_go && avs_address == OFS_ERR_CLEAR) ? wm : RD_ZERO;
    assign reassert = wr_go && avs_address == OFS_REASSERT && wm[BIT_REASSERT];

    ////////////////////////////////////////////////////////////////////////////
    // Error conditions

    // Strictly above the limit, so 31 outstanding codes are still legal
    assign ccode_set = ccode_outstanding > CC_LIMIT;

    genvar gq;
    for (gq = 0; gq < NQ; gq++) begin : g_queue
        // Compared against the live threshold: lowering it mid-run can set the flag at once
        assign q_set[gq] = queue_count[gq] >= queue_watermark_threshold[gq];

        q_set_a : assert property (q_set[gq] |=> st.qthresh[gq])
            else $error("queue threshold flag not set");

        q_hold_a : assert property (
            st.qthresh[gq] && !err_clr[BIT_Q0_THRESH + gq] |=> st.qthresh[gq])
            else $error("queue threshold flag dropped without clear");

        q_clear_a : assert property (
            err_clr[BIT_Q0_THRESH + gq] && !q_set[gq] |=> !st.qthresh[gq])
            else $error("queue threshold flag not cleared");

        q_quiet_a : assert property (
            !q_set[gq] && !st.qthresh[gq] |=> !st.qthresh[gq])
            else $error("queue threshold flag set below threshold");

        q_clr_a : assert property (
            wr_go && avs_address == OFS_ERR_CLEAR && wm[BIT_Q0_THRESH + gq]
            |=> queue_status_clear[gq] ##1 !queue_status_clear[gq])
            else $error("queue status clear pulse wrong");

        q_clr_only_a : assert property (
            !err_clr[BIT_Q0_THRESH + gq] |=> !queue_status_clear[gq])
            else $error("queue status cleared without a write");
    end

    always_comb begin
        err_word = RD_ZERO;
        err_word[BIT_CCODE_OVF] = st.ccode_ovf;
        err_word[BIT_Q0_THRESH +: NQ] = st.qthresh;
    end

    // Missed-event flags count as errors alongside the local flags
    assign any_err = (|dma_event_missed_flags) | (|qdma_event_missed_flags)
                   | st.ccode_ovf | (|st.qthresh);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st = st;
        next_st.ack = req & ~st.ack;

        // Sticky flags: a set in the cycle of a clear wins
        next_st.ccode_ovf = (st.ccode_ovf & ~err_clr[BIT_CCODE_OVF]) | ccode_set;
        next_st.qthresh = (st.qthresh & ~err_clr[BIT_Q0_THRESH +: NQ]) | q_set;

        // Watermark and exceeded fields of the queue status clear with the flag
        next_st.qclr = err_clr[BIT_Q0_THRESH +: NQ];

        // Reserved bit is kept only for read-back; it drives nothing
        if (wr_go && avs_address == OFS_REASSERT) begin
            next_st.rsv_bit = wm[BIT_RESERVED1];
        end
        if (wr_go && avs_address == OFS_IRQ_EN) begin
            next_st.ien = wm[IRQ_W-1:0];
        end

        // Status records new events only, so a flag held set raises no second status
        next_st.istat = st.istat;
        if (wr_go && avs_address == OFS_IRQ_CLEAR) begin
            next_st.istat = st.istat & ~wm[IRQ_W-1:0];
        end
        next_st.istat[IRQ_ERR_PULSE] = next_st.istat[IRQ_ERR_PULSE] | irq_bus.pulse;
        next_st.istat[IRQ_CCODE_SET] = next_st.istat[IRQ_CCODE_SET] | (ccode_set & ~st.ccode_ovf);
        next_st.istat[IRQ_QTHR_SET] = next_st.istat[IRQ_QTHR_SET] | (|(q_set & ~st.qthresh));
        next_st.irq = |(next_st.istat & next_st.ien);

        // Read data is captured in the wait cycle and stands at release
        if (avs_read && !st.ack) begin
            case (avs_address)
                OFS_ERR_FLAGS: begin
                    next_st.rdata = err_word;
                end
                OFS_REASSERT: begin
                    next_st.rdata = RD_ZERO;
                    next_st.rdata[BIT_RESERVED1] = st.rsv_bit;
                end
                OFS_IRQ_STAT: begin
                    next_st.rdata = RD_ZERO;
                    next_st.rdata[IRQ_W-1:0] = st.istat;
                end
                OFS_IRQ_EN: begin
                    next_st.rdata = RD_ZERO;
                    next_st.rdata[IRQ_W-1:0] = st.ien;
                end
                default: begin
                    next_st.rdata = RD_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pulse generation

    assign irq_bus.any_err  = any_err;
    assign irq_bus.reassert = reassert;

    dea_irq_gen u_irq_gen (
        .clk     (clk),
        .rstn    (rstn),
        .irq_bus (irq_bus)
    );

    assign avs_readdata       = st.rdata;
    assign queue_status_clear = st.qclr;
    assign error_irq          = irq_bus.pulse;
    assign irq                = st.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    cc_set_a : assert property (ccode_set |=> st.ccode_ovf)
        else $error("overflow flag not set");

    cc_hold_a : assert property (
        st.ccode_ovf && !err_clr[BIT_CCODE_OVF] |=> st.ccode_ovf)
        else $error("overflow flag dropped without clear");

    cc_clear_a : assert property (
        err_clr[BIT_CCODE_OVF] && !ccode_set |=> !st.ccode_ovf)
        else $error("overflow flag not cleared");

    cc_limit_a : assert property (
        ccode_outstanding == CC_LIMIT && !st.ccode_ovf |=> !st.ccode_ovf)
        else $error("overflow set at the limit");

    cc_quiet_a : assert property (
        !ccode_set && !st.ccode_ovf |=> !st.ccode_ovf)
        else $error("overflow flag set with no cause");

    ////////////////////////////////////////////////////////////////////////////
    // Error interrupt pulse

    err_rise_a : assert property ($rose(any_err) |=> error_irq)
        else $error("no error pulse on first error");

    err_cause_a : assert property (error_irq |-> $past(any_err))
        else $error("error pulse with no error present");

    // An error held across reset pulses once after release, so that edge is left out
    err_quiet_a : assert property (
        any_err && $past(any_err) && $past(rstn) && !reassert |=> !error_irq)
        else $error("error pulse without rise");

    no_err_a : assert property (!any_err |=> !error_irq)
        else $error("error pulse while all flags clear");

    reassert_a : assert property (
        reassert && any_err |=> error_irq ##1 !error_irq)
        else $error("reassert did not pulse");

    reassert_idle_a : assert property (
        reassert && !any_err |=> !error_irq)
        else $error("reassert pulsed with no error");

    ////////////////////////////////////////////////////////////////////////////
    // Bus and read-back

    rsv_read_a : assert property (
        avs_read && !st.ack && avs_address == OFS_ERR_FLAGS
        |=> (avs_readdata & ~(RD_ZERO | (32'h1 << BIT_CCODE_OVF) | ((32'h1 << NQ) - 32'h1))) == RD_ZERO)
        else $error("reserved error bits read nonzero");

    clr_read_a : assert property (
        avs_read && !st.ack && avs_address == OFS_ERR_CLEAR |=> avs_readdata == RD_ZERO)
        else $error("clear register read nonzero");

    error_reassert_trigger_read_a : assert property (
        avs_read && !st.ack && avs_address == OFS_REASSERT |=> !avs_readdata[BIT_REASSERT])
        else $error("reassert bit read nonzero");

    rsv_store_a : assert property (
        wr_go && avs_address == OFS_REASSERT |=> st.rsv_bit == $past(wm[BIT_RESERVED1]))
        else $error("reserved reassert bit not stored");

    wait_a : assert property (
        req && !st.ack |-> avs_waitrequest ##1 (!req || !avs_waitrequest))
        else $error("waitrequest not released after one cycle");

    wr_once_a : assert property (wr_go |=> !wr_go)
        else $error("write applied twice");

    rdata_hold_a : assert property (!(avs_read && !st.ack) |=> $stable(avs_readdata))
        else $error("read data changed without a read");

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt summary

    pulse_seen_a : assert property (error_irq |=> st.istat[IRQ_ERR_PULSE])
        else $error("error pulse not recorded");

    cc_seen_a : assert property (ccode_set && !st.ccode_ovf |=> st.istat[IRQ_CCODE_SET])
        else $error("overflow event not recorded");

    q_seen_a : assert property (|(q_set & ~st.qthresh) |=> st.istat[IRQ_QTHR_SET])
        else $error("threshold event not recorded");

    istat_hold_a : assert property (
        !(wr_go && avs_address == OFS_IRQ_CLEAR) |=> (st.istat & $past(st.istat)) == $past(st.istat))
        else $error("status bit dropped without clear");

    ien_write_a : assert property (
        wr_go && avs_address == OFS_IRQ_EN |=> st.ien == $past(wm[IRQ_W-1:0]))
        else $error("enable write lost");

    irq_mask_a : assert property (
        !(|st.ien) && !(wr_go && avs_address == OFS_IRQ_EN) |=> !irq)
        else $error("interrupt raised while masked");

    ////////////////////////////////////////////////////////////////////////////
    // Scenario coverage

    cc_cov_c : cover property (ccode_set ##1 st.ccode_ovf ##[1:60] err_clr[BIT_CCODE_OVF]);
    reassert_cov_c : cover property (reassert && any_err ##1 error_irq);
    qclr_cov_c : cover property (|queue_status_clear);
    irq_cov_c : cover property (irq ##[1:20] !irq);
    miss_cov_c : cover property (
        !any_err ##1 ((|dma_event_missed_flags) || (|qdma_event_missed_flags)) ##1 error_irq);
endmodule : dea_error_aggregator

// file: bench/tb_dma_error_aggregator.sv
module tb_dma_error_aggregator;
    timeunit 1ns;
    timeprecision 1ns;
    import dea_pkg::*;
    logic                  clk;
    logic                  rstn;
    logic [4:0]            avs_address;
    logic                  avs_read;
    logic                  avs_write;
    logic [31:0]           avs_writedata;
    logic [3:0]            avs_byteenable;
    logic [31:0]           avs_readdata;
    logic                  avs_waitrequest;
    logic [31:0]           dma_miss;
    logic [7:0]            qdma_miss;
    logic [5:0]            ccode;
    logic [1:0][4:0]       qcnt;
    logic [1:0][4:0]       qthr;
    logic [1:0]            queue_status_clear;
    logic                  error_irq;
    logic                  irq;
    int                    error_cnt;
    int                    tests_run;
    int                    pulses;
    int                    qsc0;
    int                    qsc1;
    int                    cyc;
    ////////////////////////////////////////////////////////////////////////////
    dea_error_aggregator dut_u (
        .clk                       (clk),
        .rstn                      (rstn),
        .avs_address               (avs_address),
        .avs_read                  (avs_read),
        .avs_write                 (avs_write),
        .avs_writedata             (avs_writedata),
        .avs_byteenable            (avs_byteenable),
        .avs_readdata              (avs_readdata),
        .avs_waitrequest           (avs_waitrequest),
        .dma_event_missed_flags    (dma_miss),
        .qdma_event_missed_flags   (qdma_miss),
        .ccode_outstanding         (ccode),
        .queue_count               (qcnt),
        .queue_watermark_threshold (qthr),
        .queue_status_clear        (queue_status_clear),
        .error_irq                 (error_irq),
        .irq                       (irq)
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Pulse outputs last one cycle, so they are tallied here instead of polled
    always @(posedge clk) begin
        cyc++;
        if (error_irq === 1'b1) pulses++;
        if (queue_status_clear[0] === 1'b1) qsc0++;
        if (queue_status_clear[1] === 1'b1) qsc1++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        dma_miss = 32'h0;
        qdma_miss = 8'h00;
        ccode = 6'h00;
        qcnt = '0;
        qthr = {5'h03, 5'h05};
        error_cnt = 0;
        tests_run = 0;
        pulses = 0;
        qsc0 = 0;
        qsc1 = 0;
        cyc = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rd(OFS_ERR_FLAGS, 32'h0);
        rd(OFS_ERR_CLEAR, 32'h0);
        rd(OFS_REASSERT, 32'h0);
        rd(OFS_IRQ_STAT, 32'h0);
        rd(OFS_IRQ_EN, 32'h0);
        rd(5'h18, 32'h0);
        // Overflow: the boundary count must not set the flag
        ccode <= 6'h1f;
        wt(4);
        rd(OFS_ERR_FLAGS, 32'h0);
        ccode <= 6'h20;
        wt(4);
        rd(OFS_ERR_FLAGS, 32'h0001_0000);
        chk(pulses, 1);
        ccode <= 6'h00;
        wr(OFS_ERR_CLEAR, 32'hfffe_fffc);
        rd(OFS_ERR_FLAGS, 32'h0001_0000);
        // A disabled byte lane writes as zero, so it must not clear
        avs_byteenable <= 4'hb;
        wr(OFS_ERR_CLEAR, 32'h0001_0000);
        avs_byteenable <= 4'hf;
        rd(OFS_ERR_FLAGS, 32'h0001_0000);
        wr(OFS_ERR_FLAGS, 32'hffff_ffff);
        rd(OFS_ERR_FLAGS, 32'h0001_0000);
        wr(OFS_ERR_CLEAR, 32'h0001_0000);
        rd(OFS_ERR_FLAGS, 32'h0);
        // Queue thresholds: one below, then equal
        qcnt[0] <= 5'h04;
        wt(4);
        rd(OFS_ERR_FLAGS, 32'h0);
        qcnt[0] <= 5'h05;
        wt(4);
        rd(OFS_ERR_FLAGS, 32'h1);
        chk(pulses, 2);
        qcnt[1] <= 5'h03;
        wt(4);
        rd(OFS_ERR_FLAGS, 32'h3);
        chk(pulses, 2);
        wr(OFS_REASSERT, 32'h1);
        wt(4);
        chk(pulses, 3);
        wr(OFS_REASSERT, 32'h0);
        wt(4);
        chk(pulses, 3);
        rd(OFS_REASSERT, 32'h0);
        // Conditions removed first, since a live condition beats the clear
        qcnt <= '0;
        wr(OFS_ERR_CLEAR, 32'h1);
        rd(OFS_ERR_FLAGS, 32'h2);
        chk(qsc0, 1);
        chk(qsc1, 0);
        wr(OFS_ERR_CLEAR, 32'h2);
        rd(OFS_ERR_FLAGS, 32'h0);
        chk(qsc1, 1);
        wr(OFS_REASSERT, 32'h1);
        wt(4);
        chk(pulses, 3);
        dma_miss <= 32'h0000_8000;
        wt(4);
        chk(pulses, 4);
        dma_miss <= 32'h0;
        wt(2);
        qdma_miss <= 8'h80;
        wt(4);
        chk(pulses, 5);
        qdma_miss <= 8'h00;
        // Interrupt summary: raise, mask, clear
        rd(OFS_IRQ_STAT, 32'h7);
        wr(OFS_IRQ_EN, 32'h7);
        wt(2);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_EN, 32'h0);
        wt(2);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_EN, 32'h7);
        wr(OFS_IRQ_CLEAR, 32'h7);
        wt(2);
        chk({31'h0, irq}, 32'h0);
        rd(OFS_IRQ_STAT, 32'h0);
        rd(OFS_IRQ_EN, 32'h7);
        conclude();
    end
endmodule : tb_dma_error_aggregator
